// ==== hdl/stc_pkg.sv ====
// Notes on behaviour
// - sixteen-bit count in two byte registers, wraps
// - overflow sets sticky flag until software clears
// - overflow interrupt forwarded only when enabled
// - timer mode counts every 1, 2, 4 or 8 instruction cycles by prescale code
// - counter mode counts external rising edges only
// - timer-on bit cleared stops and holds count
// - capture/compare reset input clears the count
// - crystal enable forces both oscillator pins input
// - control bit 3 powers the crystal oscillator
// - timer mode ignores the synchronisation bit
// - control bits 7:6 ignore writes, read zero
// - counter mode synchronised unless bypass bit set
// - timer clock is oscillator frequency over four
// - control register clears on power-on reset
package stc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_COUNT_LO = 8'h00;
    localparam logic [7:0] OFS_COUNT_HI = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_PINS = 8'h14;

    // field positions and control width
    localparam int OVF_BIT = 0;
    localparam int CTRL_W = 6;
    localparam int PIN_DIR_LSB = 0;
    localparam int PIN_LAT_LSB = 2;

    // reset values and count maximum
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [1:0] DIR_RESET = 2'h3;
    localparam logic [1:0] LAT_RESET = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // timing: hclk is the instruction clock, oscillator over four
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC_PER_INSTR = 4;
    localparam int TIMER_TICK_CYCLES = OSC_PER_INSTR / 4;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;

    typedef struct packed {
        logic [1:0] presc;
        logic osc_en;
        logic sync_bypass;
        logic clk_src;
        logic on;
    } stc_ctrl_t;

endpackage

// ==== hdl/stc_sync2.sv ====
`timescale 1ns/1ns
module stc_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== hdl/stc_prescale.sv ====
`timescale 1ns/1ns
module stc_prescale #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic [1:0] sel,
    // ticks
    input wire logic tick_in,
    output logic tick_out
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] mask;

    always_comb begin
        mask = W'((1 << sel) - 1);
        tick_out = tick_in && ((cnt_r & mask) == mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (clear) begin
            cnt_r <= '0;
        end else if (tick_in) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    a_div1: assert property (@(posedge clk) disable iff (!rst_n)
        sel == 2'h0 |-> tick_out == tick_in) else $error("prescale 1:1 not passing ticks");
endmodule

// ==== hdl/stc_top.sv ====
`timescale 1ns/1ns
module stc_top #(
    parameter int PRESC_W = 3
) (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // capture/compare unit
    input wire logic capture_compare_reset,
    // oscillator input pin
    input wire logic osc_input_pin_in,
    output logic osc_input_pin_out,
    output logic osc_input_pin_oe,
    // oscillator output / external clock pin
    input wire logic osc_output_ext_clock_pin_in,
    output logic osc_output_ext_clock_pin_out,
    output logic osc_output_ext_clock_pin_oe,
    // crystal amplifier and interrupt
    output logic crystal_amp_enable,
    output logic irq
);
    stc_pkg::stc_ctrl_t ctrl_r;
    logic [15:0] count_r;
    logic overflow_flag_r;
    logic overflow_irq_enable_r;
    logic [1:0] port_direction_bits_r;
    logic [1:0] port_latch_r;

    logic [7:0] addr_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [31:0] rd_val;
    logic acc;

    logic osc_in_s;
    logic ext_s;
    logic src;
    logic src_d_r;
    logic rise;
    logic raw_tick;
    logic pre_tick;
    logic sync_tick_r;
    logic inc;
    logic ovf_ev;
    logic w_lo;
    logic w_hi;
    logic w_cnt;
    logic w_flag;
    logic w_en;
    logic w_ctrl;
    logic w_pins;

    // bus access decode
    assign acc = hsel && htrans[stc_pkg::HTRANS_ACTIVE_BIT] && hready;
    assign w_lo = wr_pend_r && addr_r == stc_pkg::OFS_COUNT_LO;
    assign w_hi = wr_pend_r && addr_r == stc_pkg::OFS_COUNT_HI;
    assign w_cnt = w_lo || w_hi;
    assign w_flag = wr_pend_r && addr_r == stc_pkg::OFS_FLAG;
    assign w_en = wr_pend_r && addr_r == stc_pkg::OFS_ENABLE;
    assign w_ctrl = wr_pend_r && addr_r == stc_pkg::OFS_CTRL;
    assign w_pins = wr_pend_r && addr_r == stc_pkg::OFS_PINS;

    // only whole words are used, so hsize needs no decoding
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= acc && hwrite;
            rd_pend_r <= acc && !hwrite;
            if (acc) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // one wait state on reads so a write just ahead is always seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= !(acc && !hwrite);
            hresp <= 1'b0;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (addr_r)
            stc_pkg::OFS_COUNT_LO: rd_val[7:0] = count_r[7:0];
            stc_pkg::OFS_COUNT_HI: rd_val[7:0] = count_r[15:8];
            stc_pkg::OFS_FLAG: rd_val[stc_pkg::OVF_BIT] = overflow_flag_r;
            stc_pkg::OFS_ENABLE: rd_val[stc_pkg::OVF_BIT] = overflow_irq_enable_r;
            stc_pkg::OFS_CTRL: rd_val[stc_pkg::CTRL_W-1:0] = ctrl_r;
            stc_pkg::OFS_PINS: rd_val[3:0] = {port_latch_r, port_direction_bits_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= stc_pkg::CTRL_RESET;
        end else if (w_ctrl) begin
            ctrl_r <= hwdata[stc_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_direction_bits_r <= stc_pkg::DIR_RESET;
            port_latch_r <= stc_pkg::LAT_RESET;
        end else if (w_pins) begin
            port_direction_bits_r <= hwdata[stc_pkg::PIN_DIR_LSB +: 2];
            port_latch_r <= hwdata[stc_pkg::PIN_LAT_LSB +: 2];
        end
    end

    // pins come from outside the clock domain
    stc_sync2 u_sync_osc (
        .clk(hclk),
        .rst_n(hresetn),
        .d(osc_input_pin_in),
        .q(osc_in_s)
    );

    stc_sync2 u_sync_ext (
        .clk(hclk),
        .rst_n(hresetn),
        .d(osc_output_ext_clock_pin_in),
        .q(ext_s)
    );

    // the crystal drives the input pin; otherwise the external clock pin
    assign src = ctrl_r.osc_en ? osc_in_s : ext_s;
    assign rise = src && !src_d_r;
    // timer mode ticks every instruction cycle
    assign raw_tick = ctrl_r.clk_src ? rise : 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_d_r <= 1'b0;
        end else begin
            src_d_r <= src;
        end
    end

    stc_prescale #(
        .W(PRESC_W)
    ) u_presc (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(w_cnt),
        .sel(ctrl_r.presc),
        .tick_in(raw_tick && ctrl_r.on),
        .tick_out(pre_tick)
    );

    // synchronised path adds one hclk (instruction-clock) stage after the prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_tick_r <= 1'b0;
        end else begin
            sync_tick_r <= pre_tick;
        end
    end

    assign inc = ctrl_r.on &&
        ((ctrl_r.clk_src && !ctrl_r.sync_bypass) ? sync_tick_r : pre_tick);
    assign ovf_ev = inc && count_r == stc_pkg::COUNT_MAX && !w_cnt && !capture_compare_reset;

    // a bus write to the count wins over the capture/compare reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= stc_pkg::COUNT_RESET;
        end else if (w_cnt) begin
            if (w_lo) begin
                count_r[7:0] <= hwdata[7:0];
            end
            if (w_hi) begin
                count_r[15:8] <= hwdata[7:0];
            end
        end else if (capture_compare_reset) begin
            count_r <= stc_pkg::COUNT_RESET;
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // sticky flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_ev) begin
            overflow_flag_r <= 1'b1;
        end else if (w_flag && hwdata[stc_pkg::OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_irq_enable_r <= 1'b0;
        end else if (w_en) begin
            overflow_irq_enable_r <= hwdata[stc_pkg::OVF_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= overflow_flag_r && overflow_irq_enable_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_input_pin_oe <= 1'b0;
            osc_output_ext_clock_pin_oe <= 1'b0;
            osc_input_pin_out <= 1'b0;
            osc_output_ext_clock_pin_out <= 1'b0;
        end else begin
            // crystal forces both pins to inputs
            osc_input_pin_oe <= !ctrl_r.osc_en && !port_direction_bits_r[0];
            osc_output_ext_clock_pin_oe <= !ctrl_r.osc_en && !port_direction_bits_r[1];
            osc_input_pin_out <= port_latch_r[0];
            osc_output_ext_clock_pin_out <= port_latch_r[1];
        end
    end

    // amplifier and feedback off when disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crystal_amp_enable <= 1'b0;
        end else begin
            crystal_amp_enable <= ctrl_r.osc_en;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_wrap;
        inc && count_r == stc_pkg::COUNT_MAX && !w_cnt && !capture_compare_reset
            |=> count_r == 16'h0000 && overflow_flag_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

    property p_sticky;
        overflow_flag_r && !(w_flag && hwdata[stc_pkg::OVF_BIT]) |=> overflow_flag_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flag lost");

    property p_mask;
        overflow_flag_r && !overflow_irq_enable_r ##1 overflow_irq_enable_r == 1'b0
            |-> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt seen");

    property p_irq_on;
        overflow_flag_r && overflow_irq_enable_r |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("enabled interrupt missing");

    property p_timer;
        ctrl_r.on && !ctrl_r.clk_src && ctrl_r.presc == 2'h0 && !w_cnt
            && !capture_compare_reset |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_timer: assert property (p_timer) else $error("timer mode missed a cycle");

    property p_no_fall;
        ctrl_r.clk_src && ctrl_r.sync_bypass && ctrl_r.presc == 2'h0 && !rise && !w_cnt
            && !capture_compare_reset |=> count_r == $past(count_r);
    endproperty
    a_no_fall: assert property (p_no_fall) else $error("counted without rising edge");

    property p_hold;
        !ctrl_r.on && !w_cnt && !capture_compare_reset |=> count_r == $past(count_r);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");

    property p_ccreset;
        capture_compare_reset && !w_cnt |=> count_r == 16'h0000;
    endproperty
    a_ccreset: assert property (p_ccreset) else $error("trigger did not clear count");

    property p_pins_in;
        ctrl_r.osc_en |=> !osc_input_pin_oe && !osc_output_ext_clock_pin_oe;
    endproperty
    a_pins_in: assert property (p_pins_in) else $error("pin driven with crystal on");

    property p_amp;
        ##1 crystal_amp_enable == $past(ctrl_r.osc_en);
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier enable mismatch");

    property p_ctrl_read;
        rd_pend_r && addr_r == stc_pkg::OFS_CTRL |=> hrdata[7:6] == 2'h0 && hreadyout;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control upper bits nonzero");

    property p_sync;
        ctrl_r.on && ctrl_r.clk_src && !ctrl_r.sync_bypass && sync_tick_r && !w_cnt
            && !capture_compare_reset |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_sync: assert property (p_sync) else $error("synchronised tick not counted");

    c_overflow: cover property (ovf_ev);
    c_counter_inc: cover property (ctrl_r.clk_src && inc);
    c_ccreset: cover property (capture_compare_reset && count_r != 16'h0000);
    c_irq: cover property (irq);
endmodule

// ==== dv/stc_ext_clk.sv ====
`timescale 1ns/1ns
module stc_ext_clk (
    // reference clock
    input wire logic clk,
    // burst request
    input wire logic go,
    input wire logic sel,
    input wire logic [7:0] n,
    input wire logic slow,
    // pin levels and status
    output logic pin_osc,
    output logic pin_ext,
    output logic busy
);
    // pins stand still low between bursts; edges land off the hclk edge
    initial begin
        pin_osc = 1'b0;
        pin_ext = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                for (int i = 0; i < n; i++) begin
                    #7;
                    if (sel) begin
                        pin_ext = 1'b1;
                    end else begin
                        pin_osc = 1'b1;
                    end
                    repeat (slow ? 6 : 3) @(posedge clk);
                    #7;
                    pin_ext = 1'b0;
                    pin_osc = 1'b0;
                    repeat (slow ? 6 : 3) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic cc_rst = 1'b0;
    logic osc_out, osc_oe, ext_out, ext_oe, amp, irq;
    logic osc_lvl, ext_lvl, src_osc, src_ext, src_busy;
    logic src_go = 1'b0;
    logic src_sel = 1'b0;
    logic src_slow = 1'b0;
    logic [7:0] src_n = 8'h00;
    int errors = 0;
    int checked = 0;
    int cyc = 0;

    always #10 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    // wire level: the driving party wins
    assign osc_lvl = osc_oe ? osc_out : src_osc;
    assign ext_lvl = ext_oe ? ext_out : src_ext;

    stc_top #(.PRESC_W(3)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capture_compare_reset(cc_rst),
        .osc_input_pin_in(osc_lvl), .osc_input_pin_out(osc_out), .osc_input_pin_oe(osc_oe),
        .osc_output_ext_clock_pin_in(ext_lvl), .osc_output_ext_clock_pin_out(ext_out),
        .osc_output_ext_clock_pin_oe(ext_oe), .crystal_amp_enable(amp), .irq(irq));

    stc_ext_clk src (.clk(hclk), .go(src_go), .sel(src_sel), .n(src_n), .slow(src_slow),
        .pin_osc(src_osc), .pin_ext(src_ext), .busy(src_busy));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bus_wait;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        bus_wait();
        d = hrdata;
        // the slave only ever answers okay
        chk("hresp", {31'h0, hresp}, 32'h00000000);
    endtask

    task automatic burst(input logic sel, input logic [7:0] n, input logic slow);
        src_sel <= sel;
        src_n <= n;
        src_slow <= slow;
        src_go <= 1'b1;
        @(posedge hclk);
        src_go <= 1'b0;
        @(posedge hclk);
        while (src_busy === 1'b1) @(posedge hclk);
        // sync plus edge detect settle well inside this
        repeat (8) @(posedge hclk);
    endtask

    task automatic t_reset;
        logic [31:0] v;
        rd(stc_pkg::OFS_CTRL, v);
        chk("ctrl_reset", v, 32'h00000000);
        rd(stc_pkg::OFS_FLAG, v);
        chk("flag_reset", v, 32'h00000000);
        chk("irq_reset", {31'h0, irq}, 32'h00000000);
        chk("amp_reset", {31'h0, amp}, 32'h00000000);
        chk("oe_reset", {30'h0, osc_oe, ext_oe}, 32'h00000000);
        wr(stc_pkg::OFS_CTRL, 32'h000000FF);
        rd(stc_pkg::OFS_CTRL, v);
        chk("ctrl_upper", v, 32'h0000003F);
        rd(8'h18, v);
        chk("unmapped", v, 32'h00000000);
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
    endtask

    task automatic t_timer;
        logic [31:0] a, b;
        logic [7:0] d8;
        int t0, t1, n;
        logic ok;
        // every prescale code, sync bit toggled to show it is ignored
        for (int k = 0; k < 4; k++) begin
            wr(stc_pkg::OFS_CTRL, 32'h00000000);
            wr(stc_pkg::OFS_COUNT_LO, 32'h00000000);
            wr(stc_pkg::OFS_CTRL, {26'h0, k[1:0], 1'b0, k[0], 2'h1});
            rd(stc_pkg::OFS_COUNT_LO, a);
            t0 = cyc;
            repeat (40) @(posedge hclk);
            rd(stc_pkg::OFS_COUNT_LO, b);
            t1 = cyc;
            d8 = b[7:0] - a[7:0];
            n = 1 << k;
            ok = (d8 * n <= t1 - t0 + n - 1) && (d8 * n >= t1 - t0 - n + 1);
            chk("rate", {31'h0, ok}, 32'h00000001);
        end
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
        wr(stc_pkg::OFS_COUNT_LO, 32'h0000005A);
        repeat (20) @(posedge hclk);
        rd(stc_pkg::OFS_COUNT_LO, a);
        chk("held", a, 32'h0000005A);
    endtask

    task automatic t_overflow;
        logic [31:0] v;
        wr(stc_pkg::OFS_ENABLE, 32'h00000001);
        wr(stc_pkg::OFS_COUNT_HI, 32'h000000FF);
        wr(stc_pkg::OFS_COUNT_LO, 32'h000000F0);
        wr(stc_pkg::OFS_CTRL, 32'h00000001);
        repeat (30) @(posedge hclk);
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
        chk("irq_on", {31'h0, irq}, 32'h00000001);
        rd(stc_pkg::OFS_COUNT_HI, v);
        chk("wrap_hi", v, 32'h00000000);
        wr(stc_pkg::OFS_ENABLE, 32'h00000000);
        repeat (2) @(posedge hclk);
        chk("irq_masked", {31'h0, irq}, 32'h00000000);
        rd(stc_pkg::OFS_FLAG, v);
        chk("flag_sticky", v, 32'h00000001);
        wr(stc_pkg::OFS_ENABLE, 32'h00000001);
        repeat (2) @(posedge hclk);
        chk("irq_again", {31'h0, irq}, 32'h00000001);
        wr(stc_pkg::OFS_FLAG, 32'h00000001);
        rd(stc_pkg::OFS_FLAG, v);
        chk("flag_clear", v, 32'h00000000);
        chk("irq_off", {31'h0, irq}, 32'h00000000);
    endtask

    task automatic t_capture;
        logic [31:0] v;
        wr(stc_pkg::OFS_COUNT_HI, 32'h00000080);
        wr(stc_pkg::OFS_CTRL, 32'h00000001);
        repeat (5) @(posedge hclk);
        cc_rst <= 1'b1;
        @(posedge hclk);
        cc_rst <= 1'b0;
        rd(stc_pkg::OFS_COUNT_HI, v);
        chk("cc_hi", v, 32'h00000000);
        rd(stc_pkg::OFS_COUNT_LO, v);
        chk("cc_lo", {31'h0, v[7:0] < 8'h0C}, 32'h00000001);
        // trigger lands exactly on the cycle the count is all ones
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
        wr(stc_pkg::OFS_COUNT_HI, 32'h000000FF);
        wr(stc_pkg::OFS_COUNT_LO, 32'h000000FA);
        wr(stc_pkg::OFS_CTRL, 32'h00000001);
        repeat (5) @(posedge hclk);
        cc_rst <= 1'b1;
        @(posedge hclk);
        cc_rst <= 1'b0;
        rd(stc_pkg::OFS_FLAG, v);
        chk("cc_noflag", v, 32'h00000000);
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
    endtask

    task automatic t_counter;
        logic [31:0] v;
        wr(stc_pkg::OFS_COUNT_LO, 32'h00000000);
        wr(stc_pkg::OFS_COUNT_HI, 32'h00000000);
        wr(stc_pkg::OFS_CTRL, 32'h00000003);
        burst(1'b1, 8'h05, 1'b0);
        rd(stc_pkg::OFS_COUNT_LO, v);
        chk("sync_count", v, 32'h00000005);
        wr(stc_pkg::OFS_CTRL, 32'h00000007);
        burst(1'b1, 8'h03, 1'b1);
        rd(stc_pkg::OFS_COUNT_LO, v);
        chk("bypass_count", v, 32'h00000008);
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
        wr(stc_pkg::OFS_PINS, 32'h0000000C);
        repeat (3) @(posedge hclk);
        chk("pins_drive", {28'h0, osc_oe, ext_oe, osc_out, ext_out}, 32'h0000000F);
        wr(stc_pkg::OFS_CTRL, 32'h0000000B);
        repeat (3) @(posedge hclk);
        chk("pins_input", {30'h0, osc_oe, ext_oe}, 32'h00000000);
        chk("amp_on", {31'h0, amp}, 32'h00000001);
        burst(1'b0, 8'h04, 1'b0);
        burst(1'b1, 8'h02, 1'b0);
        rd(stc_pkg::OFS_COUNT_LO, v);
        chk("crystal_count", v, 32'h0000000C);
        wr(stc_pkg::OFS_CTRL, 32'h00000000);
        repeat (3) @(posedge hclk);
        chk("amp_off", {31'h0, amp}, 32'h00000000);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_timer();
        t_overflow();
        t_capture();
        t_counter();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        final_report();
    end
endmodule
